// ---- hw/ee_array_pkg.sv ----
// constants for the nonvolatile array controller
package ee_array_pkg;
  localparam logic [15:0] ARRAY_BASE      = 16'h0800;
  localparam logic [15:0] ARRAY_LAST      = 16'h09FF;
  localparam logic [15:0] SECURE_FIRST    = 16'h08F0;
  localparam logic [15:0] SECURE_LAST     = 16'h08FF;
  localparam int          ARRAY_BYTES     = 512;
  localparam int          ADDR_W          = 9;
  localparam int          BLOCK_MSB       = 8;
  localparam int          BLOCK_LSB       = 7;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  // option register fields
  localparam int          OPT_ARM_BIT     = 4;
  localparam logic [7:0]  OPT_RESET       = 8'hFF;
  // divider fields
  localparam int          DIV_LOCK_BIT    = 15;
  localparam logic [15:0] DIV_NV_RESET    = 16'hFFFF;
  // operation modes
  localparam logic [1:0]  MODE_BYTE_PGM   = 2'b00;
  localparam logic [1:0]  MODE_BYTE_ERASE = 2'b01;
  localparam logic [1:0]  MODE_BLOCK_ERASE = 2'b10;
  localparam logic [1:0]  MODE_BULK_ERASE = 2'b11;
  // cycle durations in 35 us ticks
  localparam logic [7:0]  TICKS_PGM       = 8'h0A;
  localparam logic [7:0]  TICKS_ERASE     = 8'h0A;
  // nonvolatile target selects
  localparam logic [1:0]  NV_OPT          = 2'b01;
  localparam logic [1:0]  NV_DIV_HI       = 2'b10;
  localparam logic [1:0]  NV_DIV_LO       = 2'b11;
endpackage

// ---- hw/eeprom_array_controller.sv ----
// nonvolatile byte array controller with timebase and protection
`timescale 1ns/1ps
`default_nettype none
module eeprom_array_controller
  import ee_array_pkg::*;
#(
  parameter int DIV_W = 16 // divider width
) (
  input  wire logic        core_clk,              // bus clock, 250 MHz
  input  wire logic        reset,                 // synchronous reset, high
  input  wire logic        crystal_clock,         // crystal reference, sampled
  input  wire logic        divider_source_select, // 1 selects bus clock
  input  wire logic        bus_wr,                // array write strobe
  input  wire logic        bus_rd,                // array read strobe
  input  wire logic [15:0] bus_addr,              // bus address
  input  wire logic [7:0]  bus_wdata,             // bus write data
  output logic      [7:0]  bus_rdata,             // read data
  input  wire logic        ctl_wr,                // control write strobe
  input  wire logic [1:0]  ctl_mode,              // erase_mode_sel_hi/lo
  input  wire logic        ctl_latch,             // bus_latch_control value
  input  wire logic        ctl_auto,              // self-timed termination
  input  wire logic        ctl_pgm,               // pgm_erase_enable value
  input  wire logic        div_wr,                // divider register write
  input  wire logic [DIV_W-1:0] div_wdata,        // divider write value
  input  wire logic        nv_rd_opt,             // read of option nv register
  input  wire logic [1:0]  nv_sel,                // latch targets an nv register
  output logic      [1:0]  mode_q,                // current mode bits
  output logic             bus_latch_control,     // latch control state
  output logic             pgm_erase_enable,      // enable state
  output logic             auto_q,                // self-timed state
  output logic      [7:0]  array_config_reg,      // volatile option copy
  output logic [DIV_W-1:0] timebase_divider,      // volatile divider
  output logic      [7:0]  option_nv_reg,         // option nv contents
  output logic [DIV_W-1:0] divider_nv_reg,        // divider nv contents
  output logic             timebase_tick,         // one 35 us tick pulse
  output logic             cycle_done             // timed cycle finished
);

  logic [7:0]       mem_q [ARRAY_BYTES]; // the array
  logic [ADDR_W-1:0] lat_addr_q;
  logic [7:0]       lat_data_q;
  logic             lat_valid_q;
  logic [1:0]       lat_nv_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic             xtal_q;
  logic             ref_edge;
  logic [7:0]       op_cnt_q;
  logic [7:0]       op_len;
  logic             init_q;
  logic [ADDR_W-1:0] clr_idx_q;
  logic             armed;
  logic             div_locked;
  logic             addr_ok;
  logic             target_blocked;
  logic             op_allowed;
  logic             op_end;
  logic [1:0]       blk;
  // protection decode pieces
  logic [15:0]      lat_full;
  logic             secure_hit;
  logic             block_hit;
  logic             wide_erase;
  // divide ratio without the lock bit
  logic [DIV_W-1:0] div_ratio;
  // nonvolatile cells: factory erased, never touched by reset
  logic [7:0]       opt_nv_q = OPT_RESET;
  logic [DIV_W-1:0] div_nv_q = DIV_W'(DIV_NV_RESET);
  // commit strobe at the end of a timed cycle
  logic             commit;

  // decoded conditions
  assign addr_ok    = (bus_addr >= ARRAY_BASE) && (bus_addr <= ARRAY_LAST);
  assign armed      = ~array_config_reg[OPT_ARM_BIT];
  assign div_locked = ~timebase_divider[DIV_LOCK_BIT];
  assign blk        = lat_addr_q[BLOCK_MSB:BLOCK_LSB];
  assign op_len     = (mode_q == MODE_BYTE_PGM) ? TICKS_PGM : TICKS_ERASE;

  // ratio, commit strobe and protection pieces
  // the lock bit sits in the top of the divider but must not stretch the ratio
  assign div_ratio  = {1'b0, timebase_divider[DIV_W-2:0]};
  assign commit     = op_end && timebase_tick;
  assign lat_full   = {7'h00, lat_addr_q} + ARRAY_BASE;
  assign secure_hit = (lat_full >= SECURE_FIRST) && (lat_full <= SECURE_LAST);
  assign block_hit  = array_config_reg[blk];
  assign wide_erase = mode_q[1]; // block or bulk erase

  // protection check for the latched target
  always_comb begin
    target_blocked = 1'b0;
    if (lat_nv_q == NV_OPT) begin
      target_blocked = armed;
    end else if (lat_nv_q != 2'b00) begin
      target_blocked = div_locked;
    end else begin
      // stored protect bit of the latched block
      if (block_hit) begin
        target_blocked = 1'b1;
      end
      // the secured window stays closed for every mode once armed
      if (armed && secure_hit) begin
        target_blocked = 1'b1;
      end
      // armed parts keep byte operations only
      if (armed && wide_erase) begin
        target_blocked = 1'b1;
      end
    end
  end
  assign op_allowed = ~target_blocked;

  // reference edge: bus clock every cycle, or rising crystal edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      xtal_q <= 1'b0;
    end else begin
      xtal_q <= crystal_clock;
    end
  end
  assign ref_edge = divider_source_select ? 1'b1 : (crystal_clock & ~xtal_q);

  // timebase divider
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_cnt_q     <= '0;
      timebase_tick <= 1'b0;
    end else begin
      timebase_tick <= 1'b0;
      if (!pgm_erase_enable) begin
        div_cnt_q <= '0;
      end else if (ref_edge) begin
        if (div_cnt_q + 1'b1 >= div_ratio) begin
          div_cnt_q     <= '0;
          timebase_tick <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  // operation duration counter
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_cnt_q <= '0;
    end else if (!pgm_erase_enable) begin
      op_cnt_q <= '0;
    end else if (timebase_tick && !op_end) begin
      op_cnt_q <= op_cnt_q + 8'h01;
    end
  end
  assign op_end = pgm_erase_enable && (op_cnt_q >= op_len);

  // completion pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= op_end && timebase_tick;
    end
  end

  // mode and self-timed bits follow every control write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= MODE_BYTE_PGM;
      auto_q <= 1'b0;
    end else if (ctl_wr) begin
      mode_q <= ctl_mode;
      auto_q <= ctl_auto;
    end
  end

  // enable: set only through the latch interlock, cleared by software or the timer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pgm_erase_enable <= 1'b0;
    end else if (ctl_wr) begin
      // a set in the closing cycle wins over the timer clear
      if (ctl_pgm && ctl_latch && bus_latch_control && lat_valid_q) begin
        pgm_erase_enable <= 1'b1;
      end else if (!ctl_pgm) begin
        pgm_erase_enable <= 1'b0;
      end else if (auto_q && commit) begin
        pgm_erase_enable <= 1'b0;
      end
    end else if (auto_q && commit) begin
      pgm_erase_enable <= 1'b0;
    end
  end

  // latch control cannot drop while high voltage may still be applied
  // a clear that arrives with enable still set is dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_latch_control <= 1'b0;
    end else if (ctl_wr && (ctl_latch || !pgm_erase_enable)) begin
      bus_latch_control <= ctl_latch;
    end
  end

  // address/data latch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lat_addr_q  <= '0;
      lat_data_q  <= ERASED_BYTE;
      lat_valid_q <= 1'b0;
      lat_nv_q    <= 2'b00;
    end else if (!bus_latch_control) begin
      lat_valid_q <= 1'b0;
    end else if (!pgm_erase_enable && (bus_wr || bus_rd) && (addr_ok || nv_sel != 2'b00)) begin
      lat_addr_q  <= bus_addr[ADDR_W-1:0];
      lat_valid_q <= 1'b1;
      lat_nv_q    <= nv_sel;
      if (bus_wr) begin
        lat_data_q <= bus_wdata;
      end
    end
  end

  // read data path
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd && addr_ok) begin
      bus_rdata <= bus_latch_control ? lat_data_q : mem_q[bus_addr[ADDR_W-1:0]];
    end
  end

  // array storage: fill walk after every reset, then committed operations
  always_ff @(posedge core_clk) begin
    if (reset) begin
      init_q    <= 1'b0;
      clr_idx_q <= '0;
    end else if (!init_q) begin
      mem_q[clr_idx_q] <= ERASED_BYTE;
      clr_idx_q        <= clr_idx_q + 1'b1;
      if (clr_idx_q == ADDR_W'(ARRAY_BYTES - 1)) begin
        init_q <= 1'b1;
      end
    end else if (op_end && timebase_tick && op_allowed && lat_nv_q == 2'b00) begin
      unique case (mode_q)
        MODE_BYTE_PGM: mem_q[lat_addr_q] <= mem_q[lat_addr_q] & lat_data_q;
        MODE_BYTE_ERASE: mem_q[lat_addr_q] <= ERASED_BYTE;
        MODE_BLOCK_ERASE: begin
          for (int i = 0; i < ARRAY_BYTES; i++) begin
            if (i[BLOCK_MSB:BLOCK_LSB] == blk) begin
              mem_q[i] <= ERASED_BYTE;
            end
          end
        end
        MODE_BULK_ERASE: begin
          // protected blocks keep their contents through a bulk erase
          for (int i = 0; i < ARRAY_BYTES; i++) begin
            if (!array_config_reg[i[BLOCK_MSB:BLOCK_LSB]]) begin
              mem_q[i] <= ERASED_BYTE;
            end
          end
        end
      endcase
    end
  end

  // option nonvolatile cell; no reset, its contents outlive every reset
  // nothing commits until the fill walk is over
  always_ff @(posedge core_clk) begin
    if (commit && op_allowed && lat_nv_q == NV_OPT && init_q) begin
      if (mode_q == MODE_BYTE_PGM) begin
        opt_nv_q <= opt_nv_q & lat_data_q;
      end else begin
        opt_nv_q <= ERASED_BYTE;
      end
    end
  end

  // divider nonvolatile cells, high and low byte programmed separately
  always_ff @(posedge core_clk) begin
    if (commit && op_allowed && init_q) begin
      if (lat_nv_q == NV_DIV_HI) begin
        if (mode_q == MODE_BYTE_PGM) begin
          div_nv_q[DIV_W-1:8] <= div_nv_q[DIV_W-1:8] & lat_data_q[DIV_W-9:0];
        end else begin
          div_nv_q[DIV_W-1:8] <= '1;
        end
      end else if (lat_nv_q == NV_DIV_LO) begin
        if (mode_q == MODE_BYTE_PGM) begin
          div_nv_q[7:0] <= div_nv_q[7:0] & lat_data_q;
        end else begin
          div_nv_q[7:0] <= ERASED_BYTE;
        end
      end
    end
  end

  // nonvolatile contents seen from outside
  assign option_nv_reg  = opt_nv_q;
  assign divider_nv_reg = div_nv_q;

  // volatile configuration copies
  always_ff @(posedge core_clk) begin
    if (reset) begin
      array_config_reg <= OPT_RESET;
      timebase_divider <= DIV_NV_RESET;
    end else if (!init_q && clr_idx_q == '0) begin
      array_config_reg <= option_nv_reg;
      timebase_divider <= divider_nv_reg;
    end else begin
      if (nv_rd_opt) begin
        array_config_reg[3:0] <= option_nv_reg[3:0];
      end
      if (div_wr && !div_locked) begin
        // the lock bit only ever comes from the nonvolatile copy at reset
        timebase_divider <= {timebase_divider[DIV_LOCK_BIT], div_wdata[DIV_W-2:0]};
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/ee_ctl_assertions.sv ----
// port assertions for the array controller
`timescale 1ns/1ps
`default_nettype none
module ee_ctl_assertions
  import ee_array_pkg::*;
#(parameter int DIV_W = 16) (
  input wire logic             core_clk,          // clock
  input wire logic             reset,             // reset
  input wire logic             ctl_wr,            // ctl write
  input wire logic             ctl_pgm,           // enable value
  input wire logic             bus_latch_control, // latch
  input wire logic             pgm_erase_enable,  // enable
  input wire logic             auto_q,            // self-timed
  input wire logic [7:0]       array_config_reg,  // option copy
  input wire logic [DIV_W-1:0] timebase_divider,  // divider
  input wire logic [7:0]       option_nv_reg,     // option nv
  input wire logic [DIV_W-1:0] divider_nv_reg,    // divider nv
  input wire logic             timebase_tick,     // tick
  input wire logic             cycle_done         // cycle end
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // enable handshake and latch interlock
  AST_PGM_NEEDS_LATCH: assert property ($rose(pgm_erase_enable) |-> bus_latch_control)
    else $error("enable rose without latch");
  AST_LATCH_HOLD: assert property (pgm_erase_enable |=> bus_latch_control)
    else $error("latch dropped while enabled");
  AST_PGM_CLEAR: assert property (ctl_wr && !ctl_pgm |=> !pgm_erase_enable)
    else $error("enable not cleared");
  // timed cycle end
  AST_AUTO_END: assert property (cycle_done && auto_q |-> ##[0:1] !pgm_erase_enable)
    else $error("self-timed end left enable set");
  AST_DONE_IN_CYCLE: assert property (cycle_done |-> pgm_erase_enable || $past(pgm_erase_enable))
    else $error("cycle end without enable");
  AST_TICK_PULSE: assert property (timebase_tick && timebase_divider[DIV_W-2:0] > 1 |=> !timebase_tick)
    else $error("tick wider than one cycle");
  // configuration load and freezes
  AST_CFG_LOAD: assert property ($fell(reset) |-> ##[0:2]
    (array_config_reg == option_nv_reg && timebase_divider == divider_nv_reg)) else $error("config not loaded");
  AST_OPT_FROZEN: assert property (!array_config_reg[OPT_ARM_BIT] |=> $stable(option_nv_reg))
    else $error("option nv changed while armed");
  AST_DIV_LOCK: assert property (!timebase_divider[DIV_LOCK_BIT] |=>
    $stable(timebase_divider) && $stable(divider_nv_reg)) else $error("divider changed while locked");
  cover property (cycle_done && auto_q);
  cover property ($fell(pgm_erase_enable) && bus_latch_control);
  cover property (!array_config_reg[OPT_ARM_BIT]);
endmodule
bind eeprom_array_controller ee_ctl_assertions #(.DIV_W(DIV_W)) u_chk (.core_clk, .reset, .ctl_wr,
  .ctl_pgm, .bus_latch_control, .pgm_erase_enable, .auto_q, .array_config_reg, .timebase_divider,
  .option_nv_reg, .divider_nv_reg, .timebase_tick, .cycle_done);
`default_nettype wire

// ---- dv/ee_cpu_model.sv ----
// processor model issuing array and control accesses
`timescale 1ns/1ps
`default_nettype none
module ee_cpu_model
  import ee_array_pkg::*;
(
  input  wire logic   core_clk,   // clock
  input  wire logic   cycle_done, // cycle end
  output logic        bus_wr,     // write
  output logic        bus_rd,     // read
  output logic [15:0] bus_addr,   // address
  output logic [7:0]  bus_wdata,  // data
  output logic        ctl_wr,     // ctl write
  output logic [1:0]  ctl_mode,   // mode
  output logic        ctl_latch,  // latch
  output logic        ctl_auto,   // self-timed
  output logic        ctl_pgm,    // enable
  output logic [1:0]  nv_sel      // nv target
);
  // idle at time zero
  initial begin
    {bus_wr, bus_rd, bus_addr, bus_wdata, nv_sel} = '0;
    {ctl_wr, ctl_mode, ctl_latch, ctl_auto, ctl_pgm} = '0;
  end
  // step just past the next edge
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  // control write pulse
  task automatic ctl(input logic [1:0] m, input logic l, a, p);
    tick;
    {ctl_mode, ctl_latch, ctl_auto, ctl_pgm, ctl_wr} = {m, l, a, p, 1'b1};
    tick;
    ctl_wr = 1'b0;
  endtask
  // array access, w high writes; read data is settled on return
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [1:0] s);
    tick;
    {bus_wr, bus_rd, bus_addr, bus_wdata, nv_sel} = {w, !w, a, d, s};
    tick;
    {bus_wr, bus_rd} = 2'b00;
  endtask
  // self-timed sequence: latch, target, enable, wait, release latch
  task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d, input logic [1:0] s,
                    output logic ok);
    ctl(m, '1, '1, '0);
    acc('1, a, d, s);
    ctl(m, '1, '1, '1);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      tick;
      ok = cycle_done;
    end
    tick;
    ctl(m, '0, '1, '0);
  endtask
endmodule
`default_nettype wire

// ---- dv/eeprom_array_controller_tb.sv ----
// self-checking bench for the array controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_array_controller_tb;
  import ee_array_pkg::*;
  logic        core_clk, reset, bus_wr, bus_rd, ctl_wr, ctl_latch, ctl_auto, ctl_pgm, div_wr, nv_rd_opt, ok;
  logic        bus_latch_control, pgm_erase_enable, auto_q, timebase_tick, cycle_done;
  logic [1:0]  ctl_mode, nv_sel, mode_q;
  logic [7:0]  bus_wdata, bus_rdata, array_config_reg, option_nv_reg;
  logic [15:0] bus_addr, div_wdata, timebase_divider, divider_nv_reg;
  logic        crystal_clock, divider_source_select;
  int          miscompares = 0;
  int          tests_run = 0;
  int          gap = 0;
  int          last_gap = 0;
  eeprom_array_controller dut (.core_clk, .reset, .crystal_clock, .divider_source_select,
    .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .ctl_wr, .ctl_mode, .ctl_latch, .ctl_auto,
    .ctl_pgm, .div_wr, .div_wdata, .nv_rd_opt, .nv_sel, .mode_q, .bus_latch_control, .pgm_erase_enable,
    .auto_q, .array_config_reg, .timebase_divider, .option_nv_reg, .divider_nv_reg, .timebase_tick,
    .cycle_done);
  ee_cpu_model cpu (.core_clk, .cycle_done, .bus_wr, .bus_rd, .bus_addr, .bus_wdata, .ctl_wr, .ctl_mode,
    .ctl_latch, .ctl_auto, .ctl_pgm, .nv_sel);
  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = !core_clk;
  end
  // crystal reference, a rising edge every fourth clock
  initial begin
    crystal_clock = 1'b0;
    forever begin
      repeat (2) @(posedge core_clk);
      #1;
      crystal_clock = !crystal_clock;
    end
  end
  // cycles between timebase ticks, for the divider checks
  always @(posedge core_clk) begin
    if (timebase_tick) begin
      last_gap <= gap;
      gap      <= 1;
    end else begin
      gap <= gap + 1;
    end
  end
  // watchdog, several times the expected run
  initial begin
    #100000;
    miscompares++;
    stop_test;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // reset 20 cycles, then wait out the fill walk
  task automatic do_reset;
    reset = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (520) @(posedge core_clk);
  endtask
  // divider write or option reread pulse
  task automatic side(input logic dw, input logic [15:0] v);
    @(posedge core_clk);
    #1;
    {div_wr, nv_rd_opt, div_wdata} = {dw, !dw, v};
    @(posedge core_clk);
    #1;
    {div_wr, nv_rd_opt} = 2'b00;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    cpu.acc('0, a, 8'h00, 2'b00);
    chk(bus_rdata, e);
  endtask
  initial begin
    {div_wr, nv_rd_opt, div_wdata} = '0;
    divider_source_select = 1'b1;
    do_reset;
    chk(array_config_reg, OPT_RESET);
    chk(timebase_divider, DIV_NV_RESET);
    rd_chk(16'h0800, ERASED_BYTE);
    cpu.ctl(MODE_BYTE_PGM, '0, '0, '1);
    chk(pgm_erase_enable, 1'b0);
    // a small ratio stands in for the 35 us count to keep the run short
    side(1'b1, 16'h0002);
    // blocks start protected; unprotect through the option nv byte
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'h00, 2'b00, ok);
    chk(ok, 1'b1);
    chk(last_gap, 2);
    rd_chk(16'h0800, ERASED_BYTE);
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'hF0, NV_OPT, ok);
    chk(array_config_reg[3:0], 4'hF);
    side(1'b0, 16'h0000);
    chk(array_config_reg[3:0], 4'h0);
    $display("test protection done");
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'hFE, 2'b00, ok);
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'hFD, 2'b00, ok);
    rd_chk(16'h0800, 8'hFC);
    // timer-less erase, then one write that clears enable and leaves the latch set
    cpu.ctl(MODE_BYTE_ERASE, '1, '0, '0);
    cpu.acc('1, 16'h0800, 8'h00, 2'b00);
    cpu.ctl(MODE_BYTE_ERASE, '1, '0, '1);
    repeat (40) @(posedge core_clk);
    cpu.ctl(MODE_BYTE_ERASE, '0, '0, '0);
    chk({pgm_erase_enable, bus_latch_control}, 2'b01);
    cpu.ctl(MODE_BYTE_ERASE, '0, '0, '0);
    rd_chk(16'h0800, ERASED_BYTE);
    cpu.op(MODE_BYTE_PGM, 16'h0880, 8'h00, 2'b00, ok);
    cpu.op(MODE_BYTE_PGM, 16'h0900, 8'h00, 2'b00, ok);
    cpu.op(MODE_BLOCK_ERASE, 16'h08C0, 8'h00, 2'b00, ok);
    chk(mode_q, MODE_BLOCK_ERASE);
    chk(auto_q, 1'b1);
    rd_chk(16'h0880, ERASED_BYTE);
    rd_chk(16'h0900, 8'h00);
    cpu.op(MODE_BULK_ERASE, 16'h0800, 8'h00, 2'b00, ok);
    rd_chk(16'h0900, ERASED_BYTE);
    // crystal reference: two rising edges per tick at a ratio of 2
    divider_source_select = 1'b0;
    cpu.op(MODE_BYTE_PGM, 16'h0980, 8'h00, 2'b00, ok);
    chk(ok, 1'b1);
    chk(last_gap, 8);
    rd_chk(16'h0980, 8'h00);
    divider_source_select = 1'b1;
    $display("test modes done");
    // lock the divider, arm the secure region, reload by reset
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'h00, NV_DIV_HI, ok);
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'h02, NV_DIV_LO, ok);
    cpu.op(MODE_BYTE_PGM, 16'h0800, 8'hEF, NV_OPT, ok);
    chk(divider_nv_reg, 16'h0002);
    do_reset;
    chk(array_config_reg, 8'hE0);
    side(1'b1, 16'h0005);
    chk(timebase_divider, 16'h0002);
    cpu.op(MODE_BYTE_PGM, 16'h0900, 8'h00, 2'b00, ok);
    cpu.op(MODE_BULK_ERASE, 16'h0900, 8'h00, 2'b00, ok);
    rd_chk(16'h0900, 8'h00);
    cpu.op(MODE_BYTE_ERASE, 16'h0900, 8'h00, 2'b00, ok);
    rd_chk(16'h0900, ERASED_BYTE);
    cpu.op(MODE_BYTE_PGM, 16'h08F0, 8'h00, 2'b00, ok);
    rd_chk(16'h08F0, ERASED_BYTE);
    cpu.op(MODE_BYTE_ERASE, 16'h0800, 8'h00, NV_OPT, ok);
    chk(option_nv_reg, 8'hE0);
    cpu.op(MODE_BYTE_ERASE, 16'h0800, 8'h00, NV_DIV_HI, ok);
    chk(divider_nv_reg, 16'h0002);
    $display("test security done");
    stop_test;
  end
endmodule
`default_nettype wire
